// ---- pkg/ftdmim_params.svh ----
// Constants of the flexible TDM input byte mapper.
// Included by its bare name; holds definitions only.
`ifndef FTDMIM_PARAMS_SVH
`define FTDMIM_PARAMS_SVH

// Register indices; byte address is four times the index
`define FTDMIM_MAP_BASE_IDX    16'hf300
`define FTDMIM_CTRL_IDX        16'hf340
`define FTDMIM_STAT_IDX        16'hf341

// Slot map entry field positions
`define FTDMIM_F_ENABLE        7
`define FTDMIM_F_REVERSE       6
`define FTDMIM_F_PIN_SEL       5
`define FTDMIM_F_CHAN_HI       4
`define FTDMIM_F_CHAN_LO       2
`define FTDMIM_F_BYTE_HI       1
`define FTDMIM_F_BYTE_LO       0

// Control and status bits
`define FTDMIM_CTRL_RX_EN      0
`define FTDMIM_STAT_OVERRUN    0
`define FTDMIM_STAT_BUSY       1

// Reset values
`define FTDMIM_MAP_RESET       8'h00
`define FTDMIM_CTRL_RESET      1'b0

// Frame geometry: 8 channels of 32 bits on each pin
`define FTDMIM_BYTES_PER_FRAME 32
`define FTDMIM_LAST_BYTE       5'h1f

`endif

// ---- pkg/ftdmim_pkg.sv ----
// Types shared by the flexible TDM input byte mapper.
// Assumes nothing of its surroundings.
package ftdmim_pkg;
   typedef logic [7:0]  ftdmim_entry_t;
   typedef logic [31:0] ftdmim_word_t;
   typedef logic [3:0]  ftdmim_chan_t;
endpackage

// ---- verilog/ftdmim_top.sv ----
// Flexible TDM input byte mapper with its output FIFO.
// Assumes a classic Wishbone master on clk_i and an external TDM source
// whose bit clock is far slower than clk_i.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "ftdmim_params.svh"

// -----------------------------------------------------------------------
// Output FIFO
// -----------------------------------------------------------------------
module ftdmim_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   wire              push;
   wire              pop;

   assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (count_reg != '0);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = mem_reg[rd_ptr_reg];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module ftdmim_top
   import ftdmim_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [31:0]          wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o,
   // TDM link
   input  wire logic                 tdm_bclk_i,
   input  wire logic                 tdm_fsync_i,
   input  wire logic                 flex_tdm_input_pin_a_i,
   input  wire logic                 flex_tdm_input_pin_b_i,
   // Channel stream to the processing core
   output logic                      chan_valid_o,
   input  wire logic                 chan_ready_i,
   output ftdmim_pkg::ftdmim_chan_t  chan_index_o,
   output ftdmim_pkg::ftdmim_word_t  chan_data_o
);
   import ftdmim_pkg::*;

   // --------------------------------------------------------------------
   // Register bus
   // --------------------------------------------------------------------
   ftdmim_entry_t flex_input_slot_map_reg [64];
   logic          rx_en_reg;
   logic          overrun_reg;
   logic          ack_reg;
   logic [31:0]   dat_reg;

   wire [15:0] reg_idx   = wb_adr_i[17:2];
   wire        adr_upper = (wb_adr_i[31:18] == 14'h0000);
   wire        access    = wb_cyc_i & wb_stb_i & ~ack_reg;
   // Writes land at the edge where the master samples ack, as classic cycles expect
   wire        wr_access = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];
   wire        map_hit   = adr_upper &
                           (reg_idx[15:6] == 10'(`FTDMIM_MAP_BASE_IDX >> 6));
   wire        ctrl_hit  = adr_upper & (reg_idx == `FTDMIM_CTRL_IDX);
   wire        stat_hit  = adr_upper & (reg_idx == `FTDMIM_STAT_IDX);
   wire [5:0]  map_sel   = reg_idx[5:0];
   logic       emit_busy_reg;
   logic       overrun_set;

   // Reserved bits read zero; unmapped indices read zero and are acked
   wire [31:0] rd_data =
      map_hit  ? {24'h000000, flex_input_slot_map_reg[map_sel]} :
      ctrl_hit ? {31'h00000000, rx_en_reg} :
      stat_hit ? {30'h00000000, emit_busy_reg, overrun_reg} : 32'h00000000;

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= access;
         if (access) begin
            dat_reg <= rd_data;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 64; i++) begin
            flex_input_slot_map_reg[i] <= `FTDMIM_MAP_RESET;
         end
         rx_en_reg <= `FTDMIM_CTRL_RESET;
      end else if (wr_access) begin
         if (map_hit) begin
            flex_input_slot_map_reg[map_sel] <= wb_dat_i[7:0];
         end
         if (ctrl_hit) begin
            rx_en_reg <= wb_dat_i[`FTDMIM_CTRL_RX_EN];
         end
      end
   end

   // Write one clears; a new overrun in the same cycle wins
   wire overrun_clr = wr_access & stat_hit & wb_dat_i[`FTDMIM_STAT_OVERRUN];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overrun_reg <= 1'b0;
      end else if (overrun_set) begin
         overrun_reg <= 1'b1;
      end else if (overrun_clr) begin
         overrun_reg <= 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // Link synchronisers and edge detection
   // --------------------------------------------------------------------
   // Stage one feeds stage two only; stage three is for edge detection
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic       bclk_prev_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_reg     <= 4'h0;
         sync2_reg     <= 4'h0;
         bclk_prev_reg <= 1'b0;
      end else begin
         sync1_reg     <= {flex_tdm_input_pin_b_i, flex_tdm_input_pin_a_i,
                           tdm_fsync_i, tdm_bclk_i};
         sync2_reg     <= sync1_reg;
         bclk_prev_reg <= sync2_reg[0];
      end
   end

   wire bclk_rise = sync2_reg[0] & ~bclk_prev_reg;
   wire fsync_s   = sync2_reg[1];
   wire pin_a_s   = sync2_reg[2];
   wire pin_b_s   = sync2_reg[3];

   // --------------------------------------------------------------------
   // Bit counting and byte capture
   // --------------------------------------------------------------------
   logic       locked_reg;
   logic       fsync_last_reg;
   logic [7:0] bit_cnt_reg;
   logic [6:0] shift_a_reg;
   logic [6:0] shift_b_reg;

   wire       frame_start = bclk_rise & fsync_s & ~fsync_last_reg;
   wire [7:0] bit_pos     = frame_start ? 8'h00 : bit_cnt_reg + 8'h01;
   wire       bit_take    = bclk_rise & rx_en_reg & (locked_reg | frame_start);
   wire       byte_done   = bit_take & (bit_pos[2:0] == 3'h7);
   wire [4:0] byte_slot   = bit_pos[7:3];
   wire       frame_done  = byte_done & (byte_slot == `FTDMIM_LAST_BYTE);
   wire [7:0] byte_a      = {shift_a_reg, pin_a_s};
   wire [7:0] byte_b      = {shift_b_reg, pin_b_s};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         locked_reg     <= 1'b0;
         fsync_last_reg <= 1'b0;
         bit_cnt_reg    <= 8'h00;
         shift_a_reg    <= 7'h00;
         shift_b_reg    <= 7'h00;
      end else begin
         if (bclk_rise) begin
            fsync_last_reg <= fsync_s;
         end
         if (!rx_en_reg) begin
            locked_reg <= 1'b0;
         end else if (frame_start) begin
            locked_reg <= 1'b1;
         end
         if (bit_take) begin
            bit_cnt_reg <= bit_pos;
            shift_a_reg <= byte_a[6:0];
            shift_b_reg <= byte_b[6:0];
         end
      end
   end

   // --------------------------------------------------------------------
   // Channel assembly
   // --------------------------------------------------------------------
   function automatic logic [7:0] ftdmim_reverse(input logic [7:0] b);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7-i];
      end
      return r;
   endfunction

   ftdmim_word_t asm_reg [16];
   ftdmim_word_t asm_next [16];
   ftdmim_word_t outbuf_reg [16];

   // Entries k and k+32 both watch byte slot k of the frame
   always_comb begin
      ftdmim_entry_t e;
      logic [7:0]    b;
      ftdmim_chan_t  ch;
      logic [1:0]    bp;
      e  = 8'h00;
      b  = 8'h00;
      ch = 4'h0;
      bp = 2'h0;
      for (int c = 0; c < 16; c++) begin
         asm_next[c] = asm_reg[c];
      end
      if (byte_done) begin
         for (int h = 0; h < 2; h++) begin
            e  = flex_input_slot_map_reg[{h[0], byte_slot}];
            b  = e[`FTDMIM_F_PIN_SEL] ? byte_b : byte_a;
            b  = e[`FTDMIM_F_REVERSE] ? ftdmim_reverse(b) : b;
            ch = {e[`FTDMIM_F_PIN_SEL], e[`FTDMIM_F_CHAN_HI:`FTDMIM_F_CHAN_LO]};
            bp = e[`FTDMIM_F_BYTE_HI:`FTDMIM_F_BYTE_LO];
            if (e[`FTDMIM_F_ENABLE]) begin
               asm_next[ch][8*(3-bp) +: 8] = b;
            end
         end
      end
   end

   // Accumulator restarts from zero each frame, so unfilled bytes are zero
   always_ff @(posedge clk_i) begin
      if (rst_i || frame_start || frame_done) begin
         for (int c = 0; c < 16; c++) begin
            asm_reg[c] <= 32'h00000000;
         end
      end else begin
         for (int c = 0; c < 16; c++) begin
            asm_reg[c] <= asm_next[c];
         end
      end
   end

   // --------------------------------------------------------------------
   // Frame emitter into the FIFO
   // --------------------------------------------------------------------
   // One frame is held; a frame finishing while it drains is dropped
   logic [3:0] emit_idx_reg;
   logic       fifo_in_ready;
   wire        emit_push  = emit_busy_reg & fifo_in_ready;
   wire        frame_load = frame_done & ~emit_busy_reg;

   assign overrun_set = frame_done & emit_busy_reg;

   always_ff @(posedge clk_i) begin
      if (frame_load) begin
         for (int c = 0; c < 16; c++) begin
            outbuf_reg[c] <= asm_next[c];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         emit_busy_reg <= 1'b0;
         emit_idx_reg  <= 4'h0;
      end else if (frame_load) begin
         emit_busy_reg <= 1'b1;
         emit_idx_reg  <= 4'h0;
      end else if (emit_push) begin
         emit_busy_reg <= (emit_idx_reg != 4'hf);
         emit_idx_reg  <= emit_idx_reg + 4'h1;
      end
   end

   ftdmim_fifo #(
      .WIDTH (36),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (emit_busy_reg),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({emit_idx_reg, outbuf_reg[emit_idx_reg]}),
      .out_valid_o (chan_valid_o),
      .out_ready_i (chan_ready_i),
      .out_data_o  ({chan_index_o, chan_data_o})
   );
endmodule

// ---- sim/ftdmim_asserts.sv ----
// Concurrent checks on the ports of the flexible TDM input byte mapper.
// Assumes one clock domain; bound to the top module at the foot of this file.
`timescale 1ns/1ps
module ftdmim_asserts
   import ftdmim_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // Clock, reset and register bus
   input wire logic         clk_i,
   input wire logic         rst_i,
   input wire logic         wb_cyc_i,
   input wire logic         wb_stb_i,
   input wire logic         wb_we_i,
   input wire logic [31:0]  wb_adr_i,
   input wire logic [31:0]  wb_dat_o,
   input wire logic         wb_ack_o,
   // Channel stream
   input wire logic         chan_valid_o,
   input wire logic         chan_ready_i,
   input wire ftdmim_chan_t chan_index_o,
   input wire ftdmim_word_t chan_data_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   sequence rd_take_s; take && !wb_we_i; endsequence
   sequence pop_s; chan_valid_o && chan_ready_i; endsequence

   ack_answer_a:
      assert property (take |=> wb_ack_o) else $error("no ack after a taken request");
   ack_pulse_a:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack wider than one cycle");
   ack_cause_a:
      assert property (wb_ack_o |-> $past(take)) else $error("ack without a request");
   reset_idle_a:
      assert property ($fell(rst_i) |-> !wb_ack_o && !chan_valid_o && wb_dat_o == 32'h0)
         else $error("outputs busy after reset");
   unmapped_zero_a:
      assert property (rd_take_s ##0 wb_adr_i[31:18] != 14'h0 |=> wb_dat_o == 32'h0)
         else $error("unmapped read not zero");
   reserved_zero_a:
      assert property (rd_take_s ##0 wb_adr_i[17:8] == 10'h3cc |=> wb_dat_o[31:8] == 24'h0)
         else $error("reserved entry bits not zero");
   hold_word_a:
      assert property (chan_valid_o && !chan_ready_i |=> chan_valid_o && $stable(chan_data_o)
         && $stable(chan_index_o)) else $error("stalled word changed");
   index_order_a:
      assert property (pop_s ##1 chan_valid_o |-> chan_index_o == ftdmim_chan_t'($past(
         chan_index_o) + 1)) else $error("channel order broken");
endmodule

bind ftdmim_top ftdmim_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_asserts (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .chan_valid_o(chan_valid_o), .chan_ready_i(chan_ready_i),
   .chan_index_o(chan_index_o), .chan_data_o(chan_data_o)
);

// ---- sim/ftdmim_src_model.sv ----
// Model of the external TDM source driving both flexible input pins.
// Assumes the receiver samples data and frame sync on the rising bit clock.
`timescale 1ns/1ps
module ftdmim_src_model (
   // Link
   output logic bclk_o,
   output logic fsync_o,
   output logic pin_a_o,
   output logic pin_b_o
);
   initial begin
      bclk_o = 0;
      fsync_o = 0;
      pin_a_o = 0;
      pin_b_o = 0;
   end
   // Clock stands still between frames; a lead bit with sync low arms the start
   task automatic send(input logic [255:0] fa, input logic [255:0] fb);
      // Step off the clk_i edge so no change races the synchroniser
      #7;
      for (int i = -1; i < 256; i++) begin
         fsync_o = (i == 0);
         if (i >= 0) begin
            pin_a_o = fa[255-i];
            pin_b_o = fb[255-i];
         end
         #100 bclk_o = 1;
         #100 bclk_o = 0;
      end
      // Released lines show the inverse so no stale bit looks valid
      pin_a_o = ~pin_a_o;
      pin_b_o = ~pin_b_o;
   endtask
endmodule

// ---- sim/ftdmim_top_tb.sv ----
// Self-checking bench for the flexible TDM input byte mapper.
// Assumes the source model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "ftdmim_params.svh"
module ftdmim_top_tb;
   import ftdmim_pkg::*;
   typedef struct packed {logic w; logic [31:0] a, d; logic [3:0] s; logic [31:0] e;} ftdmim_row_t;
   localparam ftdmim_row_t ROWS [7] = '{
      '{1'b0, 32'h3cc00, 32'h0, 4'hf, 32'h0}, '{1'b0, 32'h3ccfc, 32'h0, 4'hf, 32'h0},
      '{1'b1, 32'h3cc14, 32'hffffffa5, 4'hf, 32'h0}, '{1'b0, 32'h3cc14, 32'h0, 4'hf, 32'ha5},
      '{1'b1, 32'h3cc14, 32'h11, 4'he, 32'h0}, '{1'b0, 32'h3cc14, 32'h0, 4'hf, 32'ha5},
      '{1'b0, 32'h8003cc00, 32'h0, 4'hf, 32'h0}};
   localparam logic [31:0] CTRL_A = {14'h0, `FTDMIM_CTRL_IDX, 2'b00};
   localparam logic [31:0] STAT_A = {14'h0, `FTDMIM_STAT_IDX, 2'b00};
   logic         clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rdy = 0;
   logic [31:0]  adr = 0, wd = 0, q, dat_o;
   logic [3:0]   sel = 0;
   logic         ack, vld;
   ftdmim_chan_t idx;
   ftdmim_word_t dat;
   wire          bclk, fs, pa, pb;
   int           mismatches = 0, num_checks = 0, cycles = 0;
   ftdmim_entry_t map [64];
   ftdmim_word_t exp_w [16];
   logic [255:0] fa, fb;
   logic [7:0]   b;

   always #12.5 clk_i = ~clk_i;
   ftdmim_src_model src (.bclk_o(bclk), .fsync_o(fs), .pin_a_o(pa), .pin_b_o(pb));
   ftdmim_top #(.FIFO_DEPTH(8)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .tdm_bclk_i(bclk), .tdm_fsync_i(fs), .flex_tdm_input_pin_a_i(pa),
      .flex_tdm_input_pin_b_i(pb), .chan_valid_o(vld), .chan_ready_i(rdy),
      .chan_index_o(idx), .chan_data_o(dat));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we  <= w;
      adr <= a;
      wd  <= d;
      sel <= s;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      foreach (ROWS[i]) begin
         wb(ROWS[i].w, ROWS[i].a, ROWS[i].d, ROWS[i].s);
         if (!ROWS[i].w) chk(q, ROWS[i].e);
      end
      // Map covers every flag, both pins, all positions, and some overlaps
      for (int n = 0; n < 64; n++) begin
         map[n] = {n % 5 != 0, n[0] ^ n[5], (n[5] & n[1]) ^ n[0], n[4:2], n[1:0]};
         wb(1'b1, {14'h0, `FTDMIM_MAP_BASE_IDX + 16'(n), 2'b00}, 32'(map[n]), 4'h1);
      end
      wb(1'b1, CTRL_A, 32'h1, 4'h1);
      for (int k = 0; k < 32; k++) begin
         fa[255-8*k -: 8] = 8'(k * 37 + 5);
         fb[255-8*k -: 8] = 8'(k * 91 + 200);
      end
      foreach (exp_w[i]) exp_w[i] = '0;
      for (int n = 0; n < 64; n++) if (map[n][7]) begin
         b = map[n][5] ? fb[255-8*(n%32) -: 8] : fa[255-8*(n%32) -: 8];
         if (map[n][6]) b = {<<{b}};
         exp_w[{map[n][5], map[n][4:2]}][31-8*map[n][1:0] -: 8] = b;
      end
      // Core stalls: FIFO fills, second frame lands while words still wait
      src.send(fa, fb);
      src.send(fa, fb);
      wb(1'b0, STAT_A, 32'h0, 4'hf);
      chk(q & 32'h3, 32'h3);
      @(posedge clk_i) rdy <= 1;
      for (int i = 0; i < 16; i++) begin
         do @(negedge clk_i); while (vld !== 1'b1);
         chk({idx, dat}, {4'(i), exp_w[i]});
      end
      @(negedge clk_i) chk(36'(vld), 36'h0);
      wb(1'b1, STAT_A, 32'h1, 4'h1);
      wb(1'b0, STAT_A, 32'h0, 4'hf);
      chk(q, 32'h0);
      // Reset in mid-run clears a programmed entry
      @(posedge clk_i) rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      wb(1'b0, 32'h3cc04, 32'h0, 4'hf);
      chk(q, 32'h0);
      results();
   end
endmodule
